// ==== hw/multi_channel_timer_pwm.sv ====
/*
  five-channel 16-bit timer with sync preset/clear, per-channel pwm,
  reset-synchronised and complementary pwm on channels 3 and 4.
  assumes an apb master on core_clk; outputs go straight to pins.
*/
// Our own choices: the APB register port and the register addresses.
`timescale 1ns/1ns
module multi_channel_timer_pwm #(
  parameter int CHANNELS = timer_pwm_pkg::CHANNELS,
  parameter int CNT_W = timer_pwm_pkg::CNT_W
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [CHANNELS-1:0] compare_pin_a,
  output logic [CHANNELS-1:0] compare_pin_a_oe,
  output logic compare_pin_b3,
  output logic compare_pin_b4,
  output logic ch4_aux_out_a,
  output logic ch4_aux_out_b,
  output logic [5:0] combined_oe
);

  initial
  begin
    if (CHANNELS != 5 || CNT_W != 16)
      $error("block serves five 16-bit channels only");
  end

  // ==========================================================
  // bus decode
  wire access = psel && penable && !pready;
  wire wr = access && pwrite;
  wire in_chan = paddr >= timer_pwm_pkg::CHAN_BASE && paddr <= timer_pwm_pkg::CHAN_LAST;
  wire [7:0] chan_rel = paddr - timer_pwm_pkg::CHAN_BASE;
  wire [2:0] chan_idx = chan_rel[6:4];
  wire [7:0] chan_field = {4'h0, chan_rel[3:0]};
  wire in_buf = paddr[1:0] == 2'b00 && paddr >= timer_pwm_pkg::BUF_BASE && paddr <= 8'h7C;
  wire [1:0] buf_idx = paddr[3:2];
  wire wr_start = wr && paddr == timer_pwm_pkg::START_OFFS;
  wire wr_sync = wr && paddr == timer_pwm_pkg::SYNC_OFFS;
  wire wr_mode = wr && paddr == timer_pwm_pkg::MODE_OFFS;
  wire wr_bufen = wr && paddr == timer_pwm_pkg::BUFFER_OFFS;
  wire mapped = paddr[1:0] == 2'b00 && (paddr <= timer_pwm_pkg::PINS_OFFS || in_chan || in_buf);

  // ==========================================================
  // shared registers
  logic [CHANNELS-1:0] run_reg;
  logic [CHANNELS-1:0] sync_reg;
  logic [5:0] mode_reg;
  logic buffer_en_reg;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;

  wire [1:0] combined = mode_reg[1:0];
  wire pol3 = mode_reg[timer_pwm_pkg::POL3_POS];
  wire pol4 = mode_reg[timer_pwm_pkg::POL4_POS];
  wire rsync = combined == timer_pwm_pkg::COMBINED_RESET_SYNC;
  wire cmpl = combined == timer_pwm_pkg::COMBINED_COMPLEMENT;

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      run_reg <= '0;
      sync_reg <= '0;
      mode_reg <= '0;
      buffer_en_reg <= 1'b0;
    end
    else
    begin
      if (wr_start)
        run_reg <= pwdata[CHANNELS-1:0];
      if (wr_sync)
        sync_reg <= pwdata[CHANNELS-1:0];
      if (wr_mode)
        mode_reg <= pwdata[5:0];
      if (wr_bufen)
        buffer_en_reg <= pwdata[0];
    end
  end

  // ==========================================================
  // per-channel state
  logic [2:0] ctrl_reg [CHANNELS];
  logic [CNT_W-1:0] gra_reg [CHANNELS];
  logic [CNT_W-1:0] grb_reg [CHANNELS];
  logic [CNT_W-1:0] buf_reg [4];
  logic [CNT_W-1:0] count [CHANNELS];
  logic [CHANNELS-1:0] match_a;
  logic [CHANNELS-1:0] match_b;
  logic [CHANNELS-1:0] own_clear;
  logic [CHANNELS-1:0] chan_clear;
  logic [CHANNELS-1:0] count_wr;
  logic [CHANNELS-1:0] pwm_out_reg;
  logic [CHANNELS-1:0] pwm_en_bits;
  logic down_reg;

  wire [CNT_W-1:0] wr_value = pwdata[CNT_W-1:0];
  wire any_sync_wr = |(count_wr & sync_reg);
  wire any_sync_clear = |(own_clear & sync_reg);
  wire [CNT_W-1:0] ch3 = count[3];
  wire [CNT_W-1:0] ch4 = count[4];
  // direction turns at ch3 A match and at ch4 reaching zero
  wire turn_down = cmpl && !down_reg && run_reg[3] && ch3 == gra_reg[3];
  wire turn_up = cmpl && down_reg && run_reg[4] && ch4 == '0;
  wire rsync_clear = rsync && run_reg[3] && ch3 == gra_reg[3];
  // buffered reload at ch3 A match in either combined mode, and also at ch4 zero in complementary mode
  wire buf_load = buffer_en_reg && (rsync_clear || turn_down || turn_up);

  genvar ch;
  generate
    for (ch = 0; ch < CHANNELS; ch++)
    begin : g_chan
      wire sel = in_chan && chan_idx == 3'(ch);
      wire [1:0] clr_sel = ctrl_reg[ch][1:0];
      assign pwm_en_bits[ch] = ctrl_reg[ch][timer_pwm_pkg::PWM_EN_POS];
      wire in_comb = ch >= 3 && combined[1];
      assign count_wr[ch] = wr && sel && chan_field == timer_pwm_pkg::COUNT_OFFS;
      // compare fires at the last cycle of the matching value, while counting
      assign match_a[ch] = run_reg[ch] && count[ch] == gra_reg[ch];
      assign match_b[ch] = run_reg[ch] && count[ch] == grb_reg[ch];
      assign own_clear[ch] = !in_comb &&
        ((clr_sel == timer_pwm_pkg::CLEAR_ON_A && match_a[ch]) ||
         (clr_sel == timer_pwm_pkg::CLEAR_ON_B && match_b[ch]));
      // synced clear follows a synced own clear; in reset-sync mode ch3 ends its period at A
      assign chan_clear[ch] = own_clear[ch] || (ch == 3 && rsync_clear) ||
        (!in_comb && sync_reg[ch] && clr_sel == timer_pwm_pkg::CLEAR_SYNC && any_sync_clear);
      channel_counter #(
        .CNT_W(CNT_W)
      ) u_counter (
        .core_clk(core_clk),
        .reset(reset),
        .run(run_reg[ch]),
        // synced preset from any synced write
        .preset(count_wr[ch] || (sync_reg[ch] && any_sync_wr && !in_comb)),
        .preset_value(wr_value),
        .clear(chan_clear[ch]),
        .count_down(ch >= 3 && cmpl && (down_reg || turn_down) && !turn_up),
        .count(count[ch])
      );

      always_ff @(posedge core_clk or posedge reset)
      begin
        if (reset)
        begin
          ctrl_reg[ch] <= '0;
          gra_reg[ch] <= timer_pwm_pkg::GR_RESET;
          grb_reg[ch] <= timer_pwm_pkg::GR_RESET;
          pwm_out_reg[ch] <= 1'b0;
        end
        else
        begin
          if (wr && sel && chan_field == timer_pwm_pkg::CTRL_OFFS)
            ctrl_reg[ch] <= pwdata[2:0];
          if (wr && sel && chan_field == timer_pwm_pkg::GRA_OFFS)
            gra_reg[ch] <= wr_value;
          else if (ch >= 3 && buf_load)
            gra_reg[ch] <= buf_reg[ch == 4 ? 2 : 0];
          if (wr && sel && chan_field == timer_pwm_pkg::GRB_OFFS)
            grb_reg[ch] <= wr_value;
          else if (ch >= 3 && buf_load)
            grb_reg[ch] <= buf_reg[ch == 4 ? 3 : 1];
          // set on A, clear on B; 0% and 100% follow
          // equal registers match together, so the level holds
          if (match_a[ch] != match_b[ch])
            pwm_out_reg[ch] <= match_a[ch];
        end
      end
    end
  endgenerate

  // ==========================================================
  // buffer registers and count direction
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      for (int i = 0; i < 4; i++)
        buf_reg[i] <= timer_pwm_pkg::GR_RESET;
      down_reg <= 1'b0;
    end
    else
    begin
      if (wr && in_buf)
        buf_reg[buf_idx] <= wr_value;
      if (!cmpl)
        down_reg <= 1'b0;
      else if (turn_down)
        down_reg <= 1'b1;
      else if (turn_up)
        down_reg <= 1'b0;
    end
  end

  // ==========================================================
  // combined pair levels
  logic [2:0] pair_reg;
  logic [2:0] prime_reg;
  wire [CNT_W-1:0] pair_cmp [3];
  assign pair_cmp[0] = grb_reg[3];
  assign pair_cmp[1] = gra_reg[4];
  assign pair_cmp[2] = grb_reg[4];

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      pair_reg <= '0;
      prime_reg <= '0;
    end
    else if (rsync)
    begin
      for (int p = 0; p < 3; p++)
      begin
        // ch3 counter compares set, clear drops all
        if (rsync_clear)
          pair_reg[p] <= 1'b0;
        else if (run_reg[3] && ch3 == pair_cmp[p])
          pair_reg[p] <= 1'b1;
      end
      prime_reg <= '1;
    end
    else if (cmpl)
    begin
      for (int p = 0; p < 3; p++)
      begin
        // primary active only while ch3 below compare
        if (run_reg[3] && ch3 == pair_cmp[p])
          pair_reg[p] <= down_reg;
        // primed follows ch4, offset is the dead time
        if (run_reg[4] && ch4 == pair_cmp[p])
          prime_reg[p] <= down_reg;
      end
    end
    else
    begin
      pair_reg <= '0;
      prime_reg <= '1;
    end
  end
  // reset-sync primed is the inverse; polarity
  wire [2:0] prime_lvl = rsync ? ~pair_reg : ~prime_reg;
  wire [2:0] pol = {pol4, pol4, pol3};
  wire [2:0] pri_pin = pair_reg ^ ~pol;
  wire [2:0] sec_pin = prime_lvl ^ ~pol;

  // ==========================================================
  // pin drive and bus answer
  logic [CHANNELS-1:0] pin_a_reg;
  logic [CHANNELS-1:0] pin_a_oe_reg;
  logic [3:0] aux_reg;
  logic [5:0] comb_oe_reg;
  logic [31:0] rd_value;

  always_comb
  begin
    rd_value = '0;
    if (paddr == timer_pwm_pkg::START_OFFS)
      rd_value = {27'h0, run_reg};
    else if (paddr == timer_pwm_pkg::SYNC_OFFS)
      rd_value = {27'h0, sync_reg};
    else if (paddr == timer_pwm_pkg::MODE_OFFS)
      rd_value = {25'h0, down_reg, mode_reg};
    else if (paddr == timer_pwm_pkg::BUFFER_OFFS)
      rd_value = {31'h0, buffer_en_reg};
    else if (paddr == timer_pwm_pkg::PINS_OFFS)
      rd_value = {21'h0, pin_a_reg, aux_reg, pin_a_reg[1:0]};
    else if (in_chan && chan_idx < 3'd5 && chan_field == timer_pwm_pkg::CTRL_OFFS)
      rd_value = {29'h0, ctrl_reg[chan_idx]};
    else if (in_chan && chan_idx < 3'd5 && chan_field == timer_pwm_pkg::COUNT_OFFS)
      rd_value = {16'h0, count[chan_idx]};
    else if (in_chan && chan_idx < 3'd5 && chan_field == timer_pwm_pkg::GRA_OFFS)
      rd_value = {16'h0, gra_reg[chan_idx]};
    else if (in_chan && chan_idx < 3'd5 && chan_field == timer_pwm_pkg::GRB_OFFS)
      rd_value = {16'h0, grb_reg[chan_idx]};
    else if (in_buf)
      rd_value = {16'h0, buf_reg[buf_idx]};
  end

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      prdata_reg <= '0;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      pin_a_reg <= '0;
      pin_a_oe_reg <= '0;
      aux_reg <= '0;
      comb_oe_reg <= '0;
    end
    else
    begin
      // one wait state: ready the cycle after penable rises
      pready_reg <= psel && penable && !pready_reg;
      pslverr_reg <= psel && penable && !pready_reg && !mapped;
      if (psel && penable && !pready_reg)
        prdata_reg <= pwrite ? 32'h0 : rd_value;
      pin_a_reg <= pwm_out_reg;
      pin_a_oe_reg <= pwm_en_bits;
      // combined modes own all six pins
      if (combined[1])
      begin
        pin_a_reg[3] <= pri_pin[0];
        pin_a_reg[4] <= pri_pin[1];
        pin_a_oe_reg[4:3] <= 2'b11;
        aux_reg <= {sec_pin[2], sec_pin[1], pri_pin[2], sec_pin[0]};
        comb_oe_reg <= 6'h3F;
      end
      else
      begin
        aux_reg <= '0;
        comb_oe_reg <= '0;
      end
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign compare_pin_a = pin_a_reg;
  assign compare_pin_a_oe = pin_a_oe_reg;
  assign compare_pin_b3 = aux_reg[0];
  assign compare_pin_b4 = aux_reg[1];
  assign ch4_aux_out_a = aux_reg[2];
  assign ch4_aux_out_b = aux_reg[3];
  assign combined_oe = comb_oe_reg;

endmodule // multi_channel_timer_pwm

// ==== hw/timer_pwm_pkg.sv ====
/*
  package for the five-channel timer and pwm block: register offsets,
  field positions, reset values and mode codes.
  assumes an apb slave with 32-bit data and word-aligned registers.
*/
package timer_pwm_pkg;

  localparam int CHANNELS = 5;
  localparam int CNT_W = 16;

  // ==========================================================
  // shared registers
  localparam logic [7:0] START_OFFS = 8'h00;
  localparam logic [7:0] SYNC_OFFS = 8'h04;
  localparam logic [7:0] MODE_OFFS = 8'h08;
  localparam logic [7:0] BUFFER_OFFS = 8'h0C;
  localparam logic [7:0] PINS_OFFS = 8'h10;
  // ==========================================================
  // per-channel block: base + 16 * channel
  localparam logic [7:0] CHAN_BASE = 8'h20;
  localparam logic [7:0] CTRL_OFFS = 8'h0;
  localparam logic [7:0] COUNT_OFFS = 8'h4;
  localparam logic [7:0] GRA_OFFS = 8'h8;
  localparam logic [7:0] GRB_OFFS = 8'hC;
  localparam logic [7:0] CHAN_LAST = 8'h6C;
  // buffer registers of channels 3 and 4
  localparam logic [7:0] BUF_BASE = 8'h70;

  // ==========================================================
  // control register fields
  localparam int CLR_LO_POS = 0;
  localparam int CLR_HI_POS = 1;
  localparam int PWM_EN_POS = 2;

  // mode register fields
  localparam int COMBINED_LO_POS = 0;
  localparam int POL3_POS = 4;
  localparam int POL4_POS = 5;

  localparam logic [CNT_W-1:0] COUNT_RESET = 16'h0000;
  localparam logic [CNT_W-1:0] GR_RESET = 16'hFFFF;

  typedef enum logic [1:0]
  {
    CLEAR_NONE = 2'b00,
    CLEAR_ON_A = 2'b01,
    CLEAR_ON_B = 2'b10,
    CLEAR_SYNC = 2'b11
  } clear_sel_e;

  typedef enum logic [1:0]
  {
    COMBINED_OFF = 2'b00,
    COMBINED_RESET_SYNC = 2'b10,
    COMBINED_COMPLEMENT = 2'b11
  } combined_mode_e;

endpackage

// ==== hw/channel_counter.sv ====
/*
  one 16-bit channel counter with preset, clear and up/down count.
  assumes the caller resolves preset, clear and direction each cycle.
*/
`timescale 1ns/1ns
module channel_counter #(
  parameter int CNT_W = 16
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic run,
  input wire logic preset,
  input wire logic [CNT_W-1:0] preset_value,
  input wire logic clear,
  input wire logic count_down,
  output logic [CNT_W-1:0] count
);

  initial
  begin
    if (CNT_W < 2)
    begin
      $error("counter width too small");
    end
  end

  logic [CNT_W-1:0] count_reg;
  logic [CNT_W-1:0] count_next;

  // ==========================================================
  // preset beats clear beats counting
  assign count_next = preset ? preset_value :
                      clear ? '0 :
                      !run ? count_reg :
                      count_down ? count_reg - 1'b1 : count_reg + 1'b1;

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      count_reg <= '0;
    end
    else
    begin
      count_reg <= count_next;
    end
  end

  assign count = count_reg;

endmodule // channel_counter

// ==== test/multi_channel_timer_pwm_asserts.sv ====
/*
  checker for the timer pwm block: apb handshake and pin relations.
  assumes it is bound onto multi_channel_timer_pwm and shadows the
  mode, run and channel 0 control writes itself.
*/
`timescale 1ns/1ns
module multi_channel_timer_pwm_asserts #(
  parameter int CHANNELS = 5
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [CHANNELS-1:0] compare_pin_a,
  input wire logic [CHANNELS-1:0] compare_pin_a_oe,
  input wire logic compare_pin_b3,
  input wire logic compare_pin_b4,
  input wire logic ch4_aux_out_a,
  input wire logic ch4_aux_out_b,
  input wire logic [5:0] combined_oe
);
  // ==========================================================
  // shadow of written controls
  logic take;
  logic settled;
  logic [5:0] mode_reg;
  logic [4:0] run_reg;
  logic pwm0_reg;
  logic [3:0] quiet_reg;
  assign take = psel && penable && pwrite && !pready;
  // pins lag writes by a register stage, so wait for a quiet spell
  assign settled = (quiet_reg == 4'hF);
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      mode_reg <= 6'h00;
      run_reg <= 5'h00;
      pwm0_reg <= 1'b0;
      quiet_reg <= 4'h0;
    end
    else if (take)
    begin
      quiet_reg <= 4'h0;
      if (paddr == timer_pwm_pkg::MODE_OFFS)
        mode_reg <= pwdata[5:0];
      if (paddr == timer_pwm_pkg::START_OFFS)
        run_reg <= pwdata[4:0];
      if (paddr == timer_pwm_pkg::CHAN_BASE)
        pwm0_reg <= pwdata[timer_pwm_pkg::PWM_EN_POS];
    end
    else if (!settled)
      quiet_reg <= quiet_reg + 4'h1;
  end

  // ==========================================================
  // properties
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable && !pready;
  endsequence
  property p_answer;
    s_setup ##1 s_access |=> pready;
  endproperty
  property p_one;
    pready |=> !pready;
  endproperty
  property p_err;
    pslverr |-> pready;
  endproperty
  property p_inverse;
    settled && mode_reg[1:0] == 2'b10 |-> compare_pin_b3 == !compare_pin_a[3]
      && ch4_aux_out_a == !compare_pin_a[4] && ch4_aux_out_b == !compare_pin_b4;
  endproperty
  property p_comb_oe;
    settled && mode_reg[1] |-> combined_oe == 6'h3F && compare_pin_a_oe[4:3] == 2'b11;
  endproperty
  property p_no_overlap;
    settled && mode_reg == 6'h33 && run_reg[3] |-> !(compare_pin_a[3] && compare_pin_b3);
  endproperty
  property p_oe_pwm;
    settled && !mode_reg[1] |-> compare_pin_a_oe[0] == pwm0_reg;
  endproperty
  property p_still;
    settled && run_reg == 5'h00 |=> $stable(compare_pin_a) && $stable(compare_pin_b4);
  endproperty
  a_answer: assert property (p_answer)
    else $error("pready missing after access");
  a_one: assert property (p_one)
    else $error("pready longer than one cycle");
  a_err: assert property (p_err)
    else $error("pslverr without pready");
  a_inverse: assert property (p_inverse)
    else $error("primed output not inverse");
  a_comb_oe: assert property (p_comb_oe)
    else $error("combined pins not enabled");
  a_no_overlap: assert property (p_no_overlap)
    else $error("pair 1 outputs overlap");
  a_oe_pwm: assert property (p_oe_pwm)
    else $error("pin enable differs from pwm bit");
  a_still: assert property (p_still)
    else $error("pins moved with no counter running");
endmodule // multi_channel_timer_pwm_asserts

bind multi_channel_timer_pwm multi_channel_timer_pwm_asserts #(.CHANNELS(CHANNELS)) u_asserts (
  .core_clk(core_clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
  .compare_pin_a(compare_pin_a), .compare_pin_a_oe(compare_pin_a_oe),
  .compare_pin_b3(compare_pin_b3), .compare_pin_b4(compare_pin_b4),
  .ch4_aux_out_a(ch4_aux_out_a), .ch4_aux_out_b(ch4_aux_out_b), .combined_oe(combined_oe));

// ==== test/multi_channel_timer_pwm_tb.sv ====
/*
  self-checking bench for the timer pwm block, driven over apb.
  assumes one pready pulse per access and registered pin outputs.
*/
`timescale 1ns/1ns
module multi_channel_timer_pwm_tb;
  logic core_clk, reset, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rv;
  logic compare_pin_b3, compare_pin_b4, ch4_aux_out_a, ch4_aux_out_b;
  logic [4:0] compare_pin_a, compare_pin_a_oe;
  logic [5:0] combined_oe;
  logic [8:0] pv;
  logic [65:0] notes[$];
  logic [65:0] note;
  logic [15:0] ga, gb;
  logic [1:0] dirs;
  integer seed;
  int errors, checks_done, cycles, overlap, dead, same;
  int hi[9];

  multi_channel_timer_pwm DUT (.core_clk(core_clk), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .compare_pin_a(compare_pin_a),
    .compare_pin_a_oe(compare_pin_a_oe), .compare_pin_b3(compare_pin_b3),
    .compare_pin_b4(compare_pin_b4), .ch4_aux_out_a(ch4_aux_out_a),
    .ch4_aux_out_b(ch4_aux_out_b), .combined_oe(combined_oe));

  assign pv = {ch4_aux_out_b, ch4_aux_out_a, compare_pin_b4, compare_pin_b3, compare_pin_a};

  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // ==========================================================
  // reporting
  task automatic end_sim;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input string name, input logic [32:0] exp, input logic [32:0] got);
    checks_done++;
    if (got !== exp)
    begin
      errors++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic cnt(input string name, input int e, input int g);
    chk(name, 33'(e), 33'(g));
  endtask

  // replies are judged here, oldest note first
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      errors++;
      end_sim();
    end
    else if (pready === 1'b1)
    begin
      note = notes.pop_front();
      chk("apb reply", note[32:0], {pslverr, prdata} & note[65:33]);
    end
  end

  // ==========================================================
  // apb master
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [32:0] e, input logic [32:0] m, output logic [31:0] r);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    notes.push_back({m, e & m});
    @(posedge core_clk);
    penable <= 1'b1;
    // no limit here: the cycle ceiling ends a hung wait
    do
    begin
      @(posedge core_clk);
    end
    while (pready !== 1'b1);
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 33'h0, {1'b1, 32'h0}, rv);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, {1'b0, e}, {33{1'b1}}, rv);
  endtask

  function automatic logic [7:0] ch(input int n, input logic [7:0] off);
    return timer_pwm_pkg::CHAN_BASE + 8'(16 * n) + off;
  endfunction

  task automatic setch(input int n, input logic [31:0] c, input logic [15:0] a,
                       input logic [15:0] b);
    wr(ch(n, timer_pwm_pkg::CTRL_OFFS), c);
    wr(ch(n, timer_pwm_pkg::GRA_OFFS), {16'h0, a});
    wr(ch(n, timer_pwm_pkg::GRB_OFFS), {16'h0, b});
  endtask

  // counts high cycles of every pin over n cycles
  task automatic sample(input int n);
    overlap = 0;
    dead = 0;
    same = 0;
    for (int i = 0; i < 9; i++)
      hi[i] = 0;
    repeat (n)
    begin
      @(negedge core_clk);
      for (int i = 0; i < 9; i++)
        hi[i] += pv[i];
      overlap += pv[3] & pv[5];
      dead += !pv[3] & !pv[5];
      same += (pv[5] == pv[3]) + (pv[7] == pv[4]) + (pv[8] == pv[6]);
    end
  endtask

  // ==========================================================
  // main sequence
  initial
  begin
    seed = 32'h6AFF;
    errors = 0;
    checks_done = 0;
    cycles = 0;
    dirs = 2'b00;
    reset = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    rd(ch(0, timer_pwm_pkg::GRA_OFFS), 32'h0000FFFF);
    rd(ch(4, timer_pwm_pkg::COUNT_OFFS), 32'h0);
    apb(1'b0, 8'hFC, 32'h0, {1'b1, 32'h0}, {33{1'b1}}, rv);
    wr(timer_pwm_pkg::SYNC_OFFS, 32'h07);
    wr(ch(0, timer_pwm_pkg::COUNT_OFFS), 32'h1234);
    rd(ch(1, timer_pwm_pkg::COUNT_OFFS), 32'h1234);
    rd(ch(2, timer_pwm_pkg::COUNT_OFFS), 32'h1234);
    rd(ch(3, timer_pwm_pkg::COUNT_OFFS), 32'h0);
    repeat (20) @(posedge core_clk);
    rd(ch(0, timer_pwm_pkg::COUNT_OFFS), 32'h1234);
    // ch0 0%, ch1 100%, ch2 random, ch3 equal, ch4 cleared with ch2
    ga = 16'd5 + 16'($unsigned($random(seed)) % 20);
    gb = ga + 16'd5 + 16'($unsigned($random(seed)) % 20);
    wr(ch(0, timer_pwm_pkg::COUNT_OFFS), 32'h0);
    wr(timer_pwm_pkg::SYNC_OFFS, 32'h14);
    setch(0, 32'h6, 16'd50, 16'd30);
    setch(1, 32'h5, 16'd30, 16'd50);
    setch(2, 32'h6, ga, gb);
    setch(3, 32'h6, 16'd20, 16'd20);
    setch(4, 32'h7, ga + 16'd1, gb);
    wr(timer_pwm_pkg::START_OFFS, 32'h1F);
    sample(200);
    sample(4 * (gb + 1));
    cnt("ch2 duty", 4 * (gb - ga), hi[2]);
    cnt("ch0 duty", 0, hi[0]);
    cnt("ch1 duty", 4 * (gb + 1), hi[1]);
    cnt("ch3 duty", 0, hi[3]);
    cnt("ch4 duty", 4 * (gb - ga - 1), hi[4]);
    chk("pin enables", 33'h1F, {28'h0, compare_pin_a_oe});
    wr(timer_pwm_pkg::START_OFFS, 32'h0);
    wr(timer_pwm_pkg::SYNC_OFFS, 32'h0);
    setch(3, 32'h0, 16'd99, 16'd20);
    setch(4, 32'h0, 16'd50, 16'd80);
    // polarity 1 first, then inverted
    for (int p = 1; p >= 0; p--)
    begin
      wr(ch(3, timer_pwm_pkg::COUNT_OFFS), 32'h0);
      wr(timer_pwm_pkg::MODE_OFFS, 32'h2 | 32'(p * 48));
      wr(timer_pwm_pkg::START_OFFS, 32'h08);
      sample(150);
      sample(200);
      cnt("pair 1", p ? 158 : 42, hi[3]);
      cnt("pair 2", p ? 98 : 102, hi[4]);
      cnt("pair 3", p ? 38 : 162, hi[6]);
      cnt("primed", 0, same);
      wr(timer_pwm_pkg::START_OFFS, 32'h0);
    end
    // buffered values reach the registers only at the ch3 clear
    wr(timer_pwm_pkg::BUF_BASE, 32'd99);
    wr(timer_pwm_pkg::BUF_BASE + 8'h4, 32'd60);
    wr(timer_pwm_pkg::BUF_BASE + 8'h8, 32'd50);
    wr(timer_pwm_pkg::BUF_BASE + 8'hC, 32'd80);
    wr(timer_pwm_pkg::BUFFER_OFFS, 32'h1);
    rd(ch(3, timer_pwm_pkg::GRB_OFFS), 32'd20);
    wr(timer_pwm_pkg::START_OFFS, 32'h08);
    repeat (120) @(posedge core_clk);
    rd(ch(3, timer_pwm_pkg::GRB_OFFS), 32'd60);
    wr(timer_pwm_pkg::START_OFFS, 32'h0);
    wr(timer_pwm_pkg::BUFFER_OFFS, 32'h0);
    // counter offset of four forms the dead time
    wr(ch(3, timer_pwm_pkg::COUNT_OFFS), 32'h4);
    wr(ch(4, timer_pwm_pkg::COUNT_OFFS), 32'h0);
    setch(3, 32'h0, 16'd99, 16'd40);
    setch(4, 32'h0, 16'd60, 16'd80);
    wr(timer_pwm_pkg::MODE_OFFS, 32'h33);
    wr(timer_pwm_pkg::START_OFFS, 32'h18);
    sample(400);
    cnt("overlap", 0, overlap);
    cnt("dead time", 1, int'(dead > 0));
    chk("combined oe", 33'h3F, {27'h0, combined_oe});
    repeat (60)
    begin
      apb(1'b0, timer_pwm_pkg::MODE_OFFS, 32'h0, 33'h0, {1'b1, 32'h0}, rv);
      dirs[rv[6]] = 1'b1;
    end
    chk("directions", 33'h3, {31'h0, dirs});
    end_sim();
  end
endmodule // multi_channel_timer_pwm_tb
